// file: piot_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "piot_map.svh"
module piot_core
   import piot_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic phase_clk,
   input wire logic power_up_reset_n,
   input wire logic [6:1] irq_in_n,
   input wire logic [15:0] port_pin_i,
   output piot_port_s port_pin,
   input wire piot_bus_s bus_in,
   output logic serial_read_data,
   output logic serial_read_oe,
   output logic [3:0] irq_code,
   output logic irq_request_n
);
   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic rst_sync_n;
   logic pur_q;
   logic ph_q;
   logic [6:1] irq_pin_q;
   logic [15:0] port_q;

   piot_sync #(.W(1), .RST(1'b0)) u_rst_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(1'b1),
      .q(rst_sync_n)
   );
   piot_sync #(.W(1), .RST(1'b0)) u_pur_sync (
      .clk(clk),
      .rst_n(rst_sync_n),
      .d(power_up_reset_n),
      .q(pur_q)
   );
   piot_sync #(.W(1), .RST(1'b1)) u_ph_sync (
      .clk(clk),
      .rst_n(rst_sync_n),
      .d(phase_clk),
      .q(ph_q)
   );
   piot_sync #(.W(6), .RST(6'h3F)) u_irq_sync (
      .clk(clk),
      .rst_n(rst_sync_n),
      .d(irq_in_n),
      .q(irq_pin_q)
   );
   piot_sync #(.W(16), .RST(16'hFFFF)) u_port_sync (
      .clk(clk),
      .rst_n(rst_sync_n),
      .d(port_pin_i),
      .q(port_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // phase clock edges, seen through the synchronised copy
   logic ph_d_reg;
   wire ph_fall = ph_d_reg & ~ph_q;
   wire ph_rise = ~ph_d_reg & ph_q;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ph_d_reg <= 1'b1;
      end else begin
         ph_d_reg <= ph_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pin levels; sources 7-15 share the pins of ports 15-7
   logic [15:1] irq_lvl;
   assign irq_lvl[6:1] = irq_pin_q;
   for (genvar k = 7; k <= 15; k++) begin : g_shared
      assign irq_lvl[k] = port_q[22 - k];
   end

   function automatic piot_code_s piot_encode(input logic [15:1] m);
      piot_code_s r;
      r.code = `PIOT_CODE_IDLE;
      r.req_n = 1'b1;
      // walking down leaves the lowest set index, the highest priority
      for (int i = 15; i >= 1; i--) begin
         if (m[i]) begin
            r.code = i[3:0];
            r.req_n = 1'b0;
         end
      end
      return r;
   endfunction : piot_encode

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   logic ctrl_reg;
   wire wr_act = bus_in.wr & ~bus_in.ce_n;
   wire rd_act = bus_in.rd & ~bus_in.ce_n;
   wire [4:0] sel = bus_in.sel;
   wire [3:0] idx = sel[3:0];
   // selects above 15 drop clock mode even with chip enable high
   wire clk_mode = (ctrl_reg == PIOT_MODE_CLK) && !sel[4];
   wire low_sel = !sel[4] && (sel != `PIOT_SEL_CTRL);
   wire mask_wr = wr_act && !clk_mode && low_sel;
   wire tmr_wr = wr_act && clk_mode && low_sel && (sel <= `PIOT_SEL_LAST_TMR);
   wire soft_port_reset = wr_act && clk_mode && (sel == `PIOT_SEL_LAST_IRQ) && !bus_in.wdata;
   wire mask3_wr = wr_act && (sel == `PIOT_SEL_TMR_MASK);
   wire [3:0] tmr_bit = idx - 4'h1;

   ////////////////////////////////////////////////////////////////////////////
   // mode bit and masks
   logic [15:1] mask_reg;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl_reg <= PIOT_MODE_INT;
         mask_reg <= `PIOT_MASK_RESET;
      end else if (!pur_q) begin
         ctrl_reg <= PIOT_MODE_INT;
         mask_reg <= `PIOT_MASK_RESET;
      end else begin
         if (wr_act && sel == `PIOT_SEL_CTRL) begin
            ctrl_reg <= bus_in.wdata;
         end
         if (mask_wr) begin
            mask_reg[idx] <= bus_in.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interval timer
   logic [13:0] start_reg;
   logic [13:0] dec_reg;
   logic [13:0] snap_reg;
   logic [5:0] pre_reg;
   logic tmr_en_reg;
   logic tmr_pend_reg;
   logic [13:0] start_next;

   always_comb begin
      start_next = start_reg;
      // start bits are selects 1-14 only; selects 0 and 15 would index past the top
      if (tmr_wr) begin
         start_next[tmr_bit] = bus_in.wdata;
      end
   end

   wire tick = ph_fall && (pre_reg == `PIOT_PRESCALE_LAST);
   wire at_zero = (dec_reg == `PIOT_TMR_RESET);
   wire [13:0] dec_next = at_zero ? start_reg : dec_reg - 14'h0001;
   wire tmr_fire = tick && at_zero && tmr_en_reg;
   wire tmr_off = mask3_wr && !clk_mode && !bus_in.wdata;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         start_reg <= `PIOT_TMR_RESET;
         dec_reg <= `PIOT_TMR_RESET;
         pre_reg <= 6'h00;
      end else if (!pur_q) begin
         start_reg <= `PIOT_TMR_RESET;
         dec_reg <= `PIOT_TMR_RESET;
         pre_reg <= 6'h00;
      end else if (tmr_wr) begin
         // every start bit written restarts the count at once
         start_reg <= start_next;
         dec_reg <= start_next;
         pre_reg <= 6'h00;
      end else if (ph_fall) begin
         pre_reg <= pre_reg + 6'h01;
         if (tick) begin
            dec_reg <= dec_next;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tmr_en_reg <= 1'b0;
         tmr_pend_reg <= 1'b0;
      end else if (!pur_q) begin
         tmr_en_reg <= 1'b0;
         tmr_pend_reg <= 1'b0;
      end else begin
         if (tmr_wr) begin
            tmr_en_reg <= (start_next != `PIOT_TMR_RESET);
         end else if (tmr_off) begin
            tmr_en_reg <= 1'b0;
         end
         // a tick in the same cycle as the clearing write is kept
         tmr_pend_reg <= tmr_fire | (tmr_pend_reg & ~mask3_wr);
      end
   end

   // the snapshot stops while clock mode holds, so a read sees one value
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         snap_reg <= `PIOT_TMR_RESET;
      end else if (!pur_q) begin
         snap_reg <= `PIOT_TMR_RESET;
      end else if (tick && !clk_mode) begin
         snap_reg <= dec_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sampling, priority and output latch
   logic [15:1] samp_reg;
   piot_code_s pend_reg;
   piot_code_s out_reg;
   logic [15:1] masked;

   always_comb begin
      masked = ~samp_reg & mask_reg;
      if (tmr_en_reg) begin
         masked[`PIOT_TMR_LEVEL] = tmr_pend_reg & mask_reg[`PIOT_TMR_LEVEL];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         samp_reg <= '1;
         pend_reg <= '{code: `PIOT_CODE_IDLE, req_n: 1'b1};
         out_reg <= '{code: `PIOT_CODE_RESET, req_n: 1'b1};
      end else if (!pur_q) begin
         samp_reg <= '1;
         pend_reg <= '{code: `PIOT_CODE_IDLE, req_n: 1'b1};
         out_reg <= '{code: `PIOT_CODE_RESET, req_n: 1'b1};
      end else begin
         if (ph_fall) begin
            samp_reg <= irq_lvl;
            out_reg <= pend_reg;
         end
         if (ph_rise) begin
            pend_reg <= piot_encode(masked);
         end
      end
   end

   assign irq_code = out_reg.code;
   assign irq_request_n = out_reg.req_n;

   ////////////////////////////////////////////////////////////////////////////
   // ports: output once written, until rst_n, power-up or software port reset
   logic [15:0] port_o_reg;
   logic [15:0] port_oe_reg;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         port_o_reg <= `PIOT_PORT_RESET;
         port_oe_reg <= `PIOT_PORT_RESET;
      end else if (!pur_q) begin
         port_o_reg <= `PIOT_PORT_RESET;
         port_oe_reg <= `PIOT_PORT_RESET;
      end else if (soft_port_reset) begin
         port_oe_reg <= `PIOT_PORT_RESET;
      end else if (wr_act && sel[4]) begin
         port_o_reg[idx] <= bus_in.wdata;
         port_oe_reg[idx] <= 1'b1;
      end
   end

   assign port_pin = '{o: port_o_reg, oe: port_oe_reg};

   ////////////////////////////////////////////////////////////////////////////
   // read path: data stands in the cycle after the strobe
   logic srd_reg;
   logic soe_reg;
   wire rd_bit = (sel == `PIOT_SEL_CTRL) ? ctrl_reg :
                 sel[4] ? port_q[idx] :
                 (clk_mode && sel == `PIOT_SEL_LAST_IRQ) ? ~out_reg.req_n :
                 clk_mode ? snap_reg[tmr_bit] :
                 irq_lvl[idx];

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         srd_reg <= 1'b0;
         soe_reg <= 1'b0;
      end else begin
         srd_reg <= rd_act ? rd_bit : 1'b0;
         soe_reg <= rd_act;
      end
   end

   assign serial_read_data = srd_reg;
   assign serial_read_oe = soe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_n);

   sequence s_zero_tick;
      tick && at_zero;
   endsequence
   sequence s_reload;
      dec_reg == $past(start_reg);
   endsequence

   a_reset_outputs: assert property (!pur_q |=> irq_code == `PIOT_CODE_RESET && irq_request_n)
      else $error("outputs not at reset values");
   a_code_pairing: assert property (pur_q && irq_request_n |-> irq_code == `PIOT_CODE_IDLE ||
      irq_code == `PIOT_CODE_RESET)
      else $error("idle request with a live code");
   a_code_moment: assert property (pur_q && !ph_fall |=> $stable(out_reg))
      else $error("code changed off a falling phase edge");
   a_sample_hold: assert property (pur_q && !ph_fall |=> $stable(samp_reg))
      else $error("sample latch moved mid period");
   a_mask_write: assert property (pur_q && mask_wr |=> mask_reg[$past(idx)] == $past(bus_in.wdata))
      else $error("mask bit not stored");
   a_port_drive: assert property (pur_q && wr_act && sel[4] && !soft_port_reset |=>
      port_pin.oe[$past(idx)] && port_pin.o[$past(idx)] == $past(bus_in.wdata))
      else $error("written port not driving");
   a_port_reset: assert property (pur_q && soft_port_reset |=> port_pin.oe == `PIOT_PORT_RESET)
      else $error("software port reset left an output");
   a_timer_enable: assert property (pur_q && tmr_wr |=> tmr_en_reg == (start_reg != `PIOT_TMR_RESET))
      else $error("timer enable does not follow start value");
   a_timer_reload: assert property (pur_q && !tmr_wr ##0 s_zero_tick |=> s_reload)
      else $error("counter did not reload at zero");
   a_read_request: assert property (rd_act && clk_mode && sel == `PIOT_SEL_LAST_IRQ |=>
      serial_read_oe && serial_read_data == ~$past(irq_request_n))
      else $error("request readback wrong");
   a_read_idle: assert property (!rd_act |=> !serial_read_oe && !serial_read_data)
      else $error("read data driven without a read");
   a_port_keep: assert property (pur_q && !soft_port_reset |=>
      (port_pin.oe & $past(port_pin.oe)) == $past(port_pin.oe))
      else $error("output port fell back to input");
   a_tick_clear: assert property (pur_q && mask3_wr && !tmr_fire |=> !tmr_pend_reg)
      else $error("pending tick survived its clear");
   a_tick_keep: assert property (pur_q && tmr_fire |=> tmr_pend_reg)
      else $error("timer tick lost");
   a_timer_apart: assert property (pur_q && soft_port_reset |=> $stable(start_reg) && $stable(tmr_en_reg))
      else $error("port reset disturbed the timer");
   a_snap_freeze: assert property (pur_q && clk_mode |=> $stable(snap_reg))
      else $error("snapshot moved in clock mode");
   a_prescale_span: assert property (pur_q && tick && !tmr_wr |=> pre_reg == 6'h00)
      else $error("prescaler did not wrap after its span");
   a_reset_state: assert property (!pur_q |=> mask_reg == `PIOT_MASK_RESET && port_pin.oe == `PIOT_PORT_RESET)
      else $error("masks or ports not cleared by power-up reset");
endmodule : piot_core
`default_nettype wire

// file: piot_map.svh
`ifndef PIOT_MAP_SVH
`define PIOT_MAP_SVH
`define PIOT_SEL_CTRL 5'h00
`define PIOT_SEL_TMR_MASK 5'h03
`define PIOT_SEL_LAST_IRQ 5'h0F
`define PIOT_SEL_LAST_TMR 5'h0E
`define PIOT_TMR_LEVEL 4'h3
`define PIOT_SHARED_FIRST 4'h7
`define PIOT_SHARED_SUM 5'h16
`define PIOT_CODE_RESET 4'h0
`define PIOT_CODE_IDLE 4'hF
`define PIOT_TMR_RESET 14'h0000
`define PIOT_PRESCALE_LAST 6'h3F
`define PIOT_PORT_RESET 16'h0000
`define PIOT_MASK_RESET 15'h0000
`endif

// file: piot_pkg.sv
package piot_pkg;
   typedef enum logic {PIOT_MODE_INT, PIOT_MODE_CLK} piot_mode_e;
   typedef struct packed {
      logic [4:0] sel;
      logic ce_n;
      logic wdata;
      logic wr;
      logic rd;
   } piot_bus_s;
   typedef struct packed {
      logic [15:0] o;
      logic [15:0] oe;
   } piot_port_s;
   typedef struct packed {
      logic [3:0] code;
      logic req_n;
   } piot_code_s;
endpackage : piot_pkg

// file: piot_sync.sv
`timescale 1ns/1ps
`default_nettype none
module piot_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   // meta_reg feeds q only; nothing else may look at it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= RST;
         q <= RST;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : piot_sync
`default_nettype wire

// file: piot_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module piot_cpu_model (
   input wire logic reset_req,
   output logic phase_clk,
   output logic power_up_reset_n
);
   ////////////////////////////////////////////////////////////////////////////////
   // processor phase clock runs free, offset so its edges fall 0.5 ns before a clk rise
   initial begin
      phase_clk = 1'b0;
      #37;
      forever #100 phase_clk = ~phase_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // reset held for three phase falls, one more than the minimum, for margin
   initial begin
      power_up_reset_n = 1'b1;
      forever begin
         @(posedge reset_req);
         power_up_reset_n = 1'b0;
         repeat (3) @(negedge phase_clk);
         power_up_reset_n = 1'b1;
      end
   end
endmodule : piot_cpu_model
`default_nettype wire

// file: prog_interrupt_io_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module prog_interrupt_io_timer_test
   import piot_pkg::*;
;
   logic clk, rst_n, reset_req, rdata, roe, req_n;
   wire phase_clk;
   wire power_up_reset_n;
   logic [6:1] irq_n;
   logic [15:0] ext_pins;
   wire [15:0] port_pin_i;
   logic [3:0] code;
   piot_bus_s bus;
   piot_port_s port_pin;
   int n_fail, samples_checked, seed;
   // outside drivers only win where the port is not driving
   assign port_pin_i = (port_pin.oe & port_pin.o) | (~port_pin.oe & ext_pins);
   piot_core i_piot_core (.clk(clk), .rst_n(rst_n), .phase_clk(phase_clk), .power_up_reset_n(power_up_reset_n),
      .irq_in_n(irq_n), .port_pin_i(port_pin_i), .port_pin(port_pin), .bus_in(bus),
      .serial_read_data(rdata), .serial_read_oe(roe), .irq_code(code), .irq_request_n(req_n));
   piot_cpu_model i_piot_cpu_model (.reset_req(reset_req), .phase_clk(phase_clk),
      .power_up_reset_n(power_up_reset_n));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic bus_wr(input logic [4:0] s, input logic d, input logic ce_n = 1'b0);
      @(posedge clk);
      bus <= '{sel: s, ce_n: ce_n, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [4:0] s, input logic exp, input string what);
      @(posedge clk);
      bus <= '{sel: s, ce_n: 1'b0, wdata: 1'b0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(what, {15'h0000, exp}, {15'h0000, rdata});
      chk("read enable", 16'h0001, {15'h0000, roe});
   endtask : bus_rd
   task automatic write_masks(input logic [15:1] m);
      for (int k = 1; k <= 15; k++) bus_wr(k[4:0], m[k]);
   endtask : write_masks
   // sources 7-15 share port pins in reverse order
   task automatic set_src(input logic [15:1] p);
      irq_n <= ~p[6:1];
      for (int k = 7; k <= 15; k++) ext_pins[22-k] <= ~p[k];
   endtask : set_src
   function automatic logic [3:0] exp_code(input logic [15:1] m, input logic [15:1] p);
      exp_code = 4'hF;
      for (int k = 15; k >= 1; k--) if (m[k] & p[k]) exp_code = k[3:0];
   endfunction : exp_code
   // the code path crosses three phase edges (fall, rise, fall), so wait for it with a bound
   task automatic wait_code(input logic [3:0] c, input logic r, input string what, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge clk);
         #1;
         if (code === c && req_n === r) break;
      end
      chk(what, {12'h000, c}, {12'h000, code});
      chk("request line", {15'h0000, r}, {15'h0000, req_n});
   endtask : wait_code
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("ERROR watchdog expected finish seen timeout");
      test_done();
   end
   initial begin
      logic [15:1] mask, pat;
      logic [15:0] pv;
      logic [3:0] ec;
      logic d, r;
      int k;
      seed = 29;
      n_fail = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      reset_req = 1'b0;
      irq_n = '1;
      ext_pins = '1;
      bus = '0;
      pv = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      // look while the synchronised power-up reset still holds, before any phase fall can load a code
      repeat (3) @(posedge clk);
      #1;
      chk("reset code", 16'h0000, {12'h000, code});
      chk("reset request", 16'h0001, {15'h0000, req_n});
      chk("reset port enable", 16'h0000, port_pin.oe);
      repeat (7) @(posedge clk);
      // random masks and sources; first rounds hit highest and lowest source
      for (int n = 0; n < 12; n++) begin
         mask = 15'($random(seed));
         pat = 15'($random(seed));
         if (n == 0) {mask, pat} = {15'h7FFF, 15'h7FFF};
         if (n == 1) {mask, pat} = {15'h4000, 15'h7FFF};
         write_masks(mask);
         @(posedge clk);
         set_src(pat);
         ec = exp_code(mask, pat);
         // source 15 also shows code F, so the request is worked out on its own
         r = ((mask & pat) == 15'h0000);
         wait_code(ec, r, "priority code", 80);
         k = 1 + $unsigned($random(seed)) % 15;
         bus_rd(k[4:0], ~pat[k], "irq pin level");
      end
      ////////////////////////////////////////////////////////////////////////////////
      write_masks('0);
      bus_wr(5'h10, 1'b1, 1'b1);
      #1;
      chk("refused write", 16'h0000, port_pin.oe);
      for (int p = 0; p < 16; p++) begin
         d = 1'($random(seed));
         pv[p] = d;
         bus_wr(5'(16 + p), d);
         #1;
         chk("port enable", 16'h0001, {15'h0000, port_pin.oe[p]});
         // the pin level reaches the read path through the two-flop synchroniser
         @(posedge clk);
         ext_pins[p] <= ~d;
         bus_rd(5'(16 + p), d, "output pin");
      end
      chk("port latch", pv, port_pin.o);
      bus_wr(5'h00, 1'b1);
      bus_rd(5'h0F, 1'b0, "request readback");
      bus_wr(5'h0F, 1'b0);
      #1;
      chk("port reset", 16'h0000, port_pin.oe);
      bus_wr(5'h00, 1'b0);
      ////////////////////////////////////////////////////////////////////////////////
      ext_pins <= '1;
      bus_wr(5'h03, 1'b1);
      @(posedge clk);
      set_src(15'h0004);
      wait_code(4'h3, 1'b0, "outside level 3", 80);
      bus_wr(5'h00, 1'b1);
      bus_wr(5'h01, 1'b1);
      wait_code(4'hF, 1'b1, "level 3 blocked", 80);
      // start value one: two full prescale spans before the tick
      repeat (760) @(posedge clk);
      #1;
      chk("timer early", 16'h000F, {12'h000, code});
      wait_code(4'h3, 1'b0, "timer tick", 400);
      bus_wr(5'h00, 1'b0);
      bus_wr(5'h03, 1'b1);
      wait_code(4'hF, 1'b1, "tick cleared", 80);
      // start 2001h; one tick outside clock mode loads the snapshot with 2000h
      bus_wr(5'h00, 1'b1);
      bus_wr(5'h0E, 1'b1);
      bus_wr(5'h00, 1'b0);
      repeat (760) @(posedge clk);
      bus_wr(5'h00, 1'b1);
      bus_rd(5'h00, 1'b1, "mode bit");
      bus_rd(5'h01, 1'b0, "snapshot low");
      bus_rd(5'h0E, 1'b1, "snapshot high");
      // a tick falls inside this wait; in clock mode the snapshot must not follow it
      repeat (600) @(posedge clk);
      bus_rd(5'h01, 1'b0, "snapshot frozen");
      bus_wr(5'h0E, 1'b0);
      bus_wr(5'h01, 1'b0);
      bus_wr(5'h00, 1'b0);
      wait_code(4'h3, 1'b0, "timer disabled", 80);
      ////////////////////////////////////////////////////////////////////////////////
      @(posedge clk);
      reset_req <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("power reset code", 16'h0000, {12'h000, code});
      chk("power reset request", 16'h0001, {15'h0000, req_n});
      reset_req = 1'b0;
      for (int i = 0; i < 200 && power_up_reset_n !== 1'b1; i++) @(posedge clk);
      repeat (5) @(posedge clk);
      set_src('1);
      wait_code(4'hF, 1'b1, "masks cleared", 80);
      test_done();
   end
endmodule : prog_interrupt_io_timer_test
`default_nettype wire
